// File: tpc_regs.vh
// register offsets, field positions and reset values of the timer block
//
// Behaviour
// [RULE1] edge/level 00 releases the channel pin
// [RULE2] mode 00 captures on selected edges
// [RULE3] mode 01 compares: none, toggle, clear, set
// [RULE4] mode 1X gives edge-aligned pwm, polarity by field
// [RULE5] center select forces center-aligned pwm everywhere
// [RULE6] software keeps pin stable before capture
// [RULE7] channel value holds capture or compare, reset zero
// [RULE8] capture read freezes both bytes until other
// [RULE9] compare write transfers after both bytes written
// [RULE10] center select makes counter count up/down
// [RULE11] clock source resets off; 01 is bus clock
// [RULE12] external clock at most quarter bus rate
// [RULE13] counting pauses during background debug
// [RULE14] up counter wraps at terminal count to zero
// [RULE15] up/down counter turns at modulus and zero
// [RULE16] overflow request is flag and enable level
// [RULE17] up mode sets overflow at terminal wrap
// [RULE18] up/down sets overflow on turning downward
// [RULE19] counter read snapshots both bytes
// [RULE20] counter write zeroes count and snapshot state
// [RULE21] event flag: read set, write zero clears
// [RULE22] edge pwm value loads when counter is zero
`ifndef TPC_REGS_VH
`define TPC_REGS_VH

// ------------------------------------------------------------
// byte register offsets
// ------------------------------------------------------------
`define TPC_ADDR_W     5
`define TPC_OFS_TSC    5'h00
`define TPC_OFS_CNTH   5'h01
`define TPC_OFS_CNTL   5'h02
`define TPC_OFS_MODH   5'h03
`define TPC_OFS_MODL   5'h04
`define TPC_CH_BASE    5
`define TPC_CH_STRIDE  3

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TPC_BIT_FLAG   7
`define TPC_BIT_IE     6
`define TPC_BIT_CPWM   5
`define TPC_BIT_MSB    5
`define TPC_BIT_MSA    4
`define TPC_CLKS_HI    4
`define TPC_CLKS_LO    3
`define TPC_ELS_HI     3
`define TPC_ELS_LO     2
`define TPC_PS_HI      2

// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define TPC_RST_16     16'h0000
`define TPC_CLK_OFF    2'h0
`define TPC_CLK_BUS    2'h1
`define TPC_CLK_FIX    2'h2
`define TPC_CLK_EXT    2'h3

`endif

// File: tpc_timer.v
// timer with shared counter and capture/compare/pwm channels
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_regs.vh"

// ------------------------------------------------------------
// three-stage input filter
// ------------------------------------------------------------
module tpc_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire [W-1:0] din,
	output reg  [W-1:0] dout
);
	reg [W-1:0] s1;
	reg [W-1:0] s2;
	reg [W-1:0] s3;
	integer k;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1   <= {W{1'b0}};
			s2   <= {W{1'b0}};
			s3   <= {W{1'b0}};
			dout <= {W{1'b0}};
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			// a level counts only once two later stages agree
			for (k = 0; k < W; k = k + 1) begin
				if (s2[k] == s3[k]) begin
					dout[k] <= s3[k];
				end
			end
		end
	end
endmodule

// ------------------------------------------------------------
// timer top
// ------------------------------------------------------------
module tpc_timer #(
	parameter NCH = 2
) (
	input  wire                    clk,
	input  wire                    rstn,
	input  wire [`TPC_ADDR_W-1:0]  addr,
	input  wire [7:0]              wdata,
	input  wire                    wr,
	input  wire                    rd,
	output reg  [7:0]              rdata,
	input  wire                    bdm_active,
	input  wire                    fixed_system_clock,
	input  wire                    ext_clk,
	input  wire [NCH-1:0]          chan_pin_in,
	output wire [NCH-1:0]          chan_pin_out,
	output wire [NCH-1:0]          chan_pin_oe,
	output wire [NCH-1:0]          chan_irq,
	output wire                    ovf_irq
);
	// timer status/control fields
	reg        counter_overflow_flag;
	reg        overflow_irq_enable;
	reg        center_pwm_select;
	reg [1:0]  clock_source_field;
	reg [2:0]  prescale;
	reg        tof_armed;
	// counter, modulus and coherency state
	reg [15:0] cnt;
	reg        dir_down;
	reg [15:0] modv;
	reg [15:0] mod_buf;
	reg        mod_wh;
	reg        mod_wl;
	reg [15:0] cnt_snap;
	reg        cnt_lat;
	reg        cnt_hdone;
	reg        cnt_ldone;
	reg [6:0]  ps_cnt;
	reg        prev_fix;
	reg        prev_ext;
	reg [NCH-1:0] prev_pin;

	wire [NCH+1:0] filt;
	wire [NCH-1:0] pin_f = filt[NCH-1:0];
	wire [NCH-1:0] pin_rise = pin_f & ~prev_pin;
	wire [NCH-1:0] pin_fall = ~pin_f & prev_pin;

	tpc_sync #(.W(NCH + 2)) u_sync (
		.clk  (clk),
		.rstn (rstn),
		.din  ({ext_clk, fixed_system_clock, chan_pin_in}),
		.dout (filt)
	);

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	wire w_tsc  = wr && (addr == `TPC_OFS_TSC);
	wire r_tsc  = rd && (addr == `TPC_OFS_TSC);
	wire w_cnt  = wr && ((addr == `TPC_OFS_CNTH) || (addr == `TPC_OFS_CNTL));
	wire r_cnth = rd && (addr == `TPC_OFS_CNTH);
	wire r_cntl = rd && (addr == `TPC_OFS_CNTL);
	wire w_modh = wr && (addr == `TPC_OFS_MODH);
	wire w_modl = wr && (addr == `TPC_OFS_MODL);

	// ------------------------------------------------------------
	// count tick: source select, prescaler, debug hold
	// ------------------------------------------------------------
	wire fix_rise = filt[NCH] & ~prev_fix;
	wire ext_rise = filt[NCH+1] & ~prev_ext;
	reg  src_tick;
	always @* begin
		case (clock_source_field)
		`TPC_CLK_BUS: src_tick = 1'b1; // RULE11
		`TPC_CLK_FIX: src_tick = fix_rise;
		`TPC_CLK_EXT: src_tick = ext_rise; // RULE12
		default:      src_tick = 1'b0; // RULE11
		endcase
	end
	wire [6:0] ps_mask = 7'h7F >> (3'h7 - prescale);
	wire tick = src_tick && !bdm_active && ((ps_cnt & ps_mask) == ps_mask); // RULE13

	wire [15:0] term = (modv == 16'h0000) ? 16'hFFFF : modv;
	wire ovf_ev = tick && !w_cnt &&
		(center_pwm_select ? (!dir_down && cnt == modv) : (cnt == term)); // RULE17 RULE18

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ps_cnt   <= 7'h00;
			prev_fix <= 1'b0;
			prev_ext <= 1'b0;
			prev_pin <= {NCH{1'b0}};
		end else begin
			prev_fix <= filt[NCH];
			prev_ext <= filt[NCH+1];
			prev_pin <= pin_f;
			if (src_tick && !bdm_active) begin
				ps_cnt <= ps_cnt + 7'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// main counter
	// ------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt      <= `TPC_RST_16;
			dir_down <= 1'b0;
		end else if (w_cnt) begin
			cnt      <= `TPC_RST_16; // RULE20
			dir_down <= 1'b0;
		end else if (tick) begin
			if (!center_pwm_select) begin
				cnt <= (cnt == term) ? 16'h0000 : cnt + 16'h0001; // RULE14
			end else if (!dir_down) begin
				// each end value lasts one tick before turning
				if (cnt == modv) begin
					dir_down <= 1'b1; // RULE10 RULE15
					cnt      <= cnt - 16'h0001;
				end else begin
					cnt <= cnt + 16'h0001;
				end
			end else if (cnt == 16'h0000) begin
				dir_down <= 1'b0; // RULE15
				cnt      <= 16'h0001;
			end else begin
				cnt <= cnt - 16'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// counter read snapshot
	// ------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_snap  <= `TPC_RST_16;
			cnt_lat   <= 1'b0;
			cnt_hdone <= 1'b0;
			cnt_ldone <= 1'b0;
		end else if (w_cnt) begin
			cnt_lat   <= 1'b0; // RULE20
			cnt_hdone <= 1'b0;
			cnt_ldone <= 1'b0;
		end else if (r_cnth || r_cntl) begin
			if (!cnt_lat) begin
				cnt_snap <= cnt; // RULE19
			end
			if ((r_cnth && cnt_ldone) || (r_cntl && cnt_hdone)) begin
				cnt_lat   <= 1'b0; // RULE19
				cnt_hdone <= 1'b0;
				cnt_ldone <= 1'b0;
			end else begin
				cnt_lat   <= 1'b1;
				cnt_hdone <= cnt_hdone | r_cnth;
				cnt_ldone <= cnt_ldone | r_cntl;
			end
		end
	end

	// ------------------------------------------------------------
	// timer status/control and modulus
	// ------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			counter_overflow_flag <= 1'b0;
			overflow_irq_enable   <= 1'b0;
			center_pwm_select     <= 1'b0;
			clock_source_field    <= `TPC_CLK_OFF; // RULE11
			prescale              <= 3'h0;
			tof_armed             <= 1'b0;
			modv                  <= `TPC_RST_16;
			mod_buf               <= `TPC_RST_16;
			mod_wh                <= 1'b0;
			mod_wl                <= 1'b0;
		end else begin
			if (ovf_ev) begin
				// a fresh overflow restarts the clearing sequence
				counter_overflow_flag <= 1'b1;
				tof_armed             <= 1'b0;
			end else if (w_tsc && tof_armed && !wdata[`TPC_BIT_FLAG]) begin
				counter_overflow_flag <= 1'b0;
				tof_armed             <= 1'b0;
			end else if (r_tsc && counter_overflow_flag) begin
				tof_armed <= 1'b1;
			end
			if (w_tsc) begin
				overflow_irq_enable <= wdata[`TPC_BIT_IE];
				center_pwm_select   <= wdata[`TPC_BIT_CPWM];
				clock_source_field  <= wdata[`TPC_CLKS_HI:`TPC_CLKS_LO];
				prescale            <= wdata[`TPC_PS_HI:0];
				mod_wh              <= 1'b0;
				mod_wl              <= 1'b0;
			end else if (mod_wh && mod_wl && (!center_pwm_select || ovf_ev)) begin
				modv   <= mod_buf;
				mod_wh <= 1'b0;
				mod_wl <= 1'b0;
			end else begin
				if (w_modh) begin
					mod_buf[15:8] <= wdata;
					mod_wh        <= 1'b1;
				end
				if (w_modl) begin
					mod_buf[7:0] <= wdata;
					mod_wl       <= 1'b1;
				end
			end
		end
	end

	assign ovf_irq = counter_overflow_flag & overflow_irq_enable; // RULE16

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	wire [8*NCH-1:0] ch_rd;
	genvar i;
	generate
	for (i = 0; i < NCH; i = i + 1) begin : g_ch
		localparam integer           A_IDX = `TPC_CH_BASE + `TPC_CH_STRIDE * i;
		localparam [`TPC_ADDR_W-1:0] A_SC  = A_IDX[`TPC_ADDR_W-1:0];
		localparam [`TPC_ADDR_W-1:0] A_VH = A_SC + 5'h01;
		localparam [`TPC_ADDR_W-1:0] A_VL = A_SC + 5'h02;
		reg        flag;
		reg        armed;
		reg        ie;
		reg        msb;
		reg        msa;
		reg [1:0]  els;
		reg [15:0] val;
		reg [15:0] vbuf;
		reg        wh;
		reg        wl;
		reg        lat;
		reg        hdone;
		reg        ldone;
		reg        pout;
		reg [7:0]  rsel;

		wire w_sc = wr && (addr == A_SC);
		wire r_sc = rd && (addr == A_SC);
		wire w_vh = wr && (addr == A_VH);
		wire w_vl = wr && (addr == A_VL);
		wire r_vh = rd && (addr == A_VH);
		wire r_vl = rd && (addr == A_VL);

		wire pin_en = (els != 2'b00); // RULE1
		wire cen    = center_pwm_select; // RULE5 RULE10
		wire cap    = pin_en && !cen && !msb && !msa; // RULE2
		wire cmp    = !cen && !msb && msa; // RULE3
		wire epwm   = pin_en && !cen && msb; // RULE4
		wire match  = tick && (cnt == val);
		wire cap_ev = cap && ((els[0] && pin_rise[i]) || (els[1] && pin_fall[i])); // RULE2
		wire cmp_ev = match && (cmp || epwm || (cen && pin_en));
		wire ev     = cap_ev || cmp_ev;
		// level compare gives 0% at zero and for center values with bit 15 set, 100% above modulus
		wire lt     = (cen && val[15]) ? 1'b0 : (cnt < val);
		wire load   = cmp || (epwm && cnt == 16'h0000) || (cen && ovf_ev); // RULE22

		always @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				flag  <= 1'b0;
				armed <= 1'b0;
				ie    <= 1'b0;
				msb   <= 1'b0;
				msa   <= 1'b0;
				els   <= 2'b00;
				val   <= `TPC_RST_16; // RULE7
				vbuf  <= `TPC_RST_16;
				wh    <= 1'b0;
				wl    <= 1'b0;
				lat   <= 1'b0;
				hdone <= 1'b0;
				ldone <= 1'b0;
				pout  <= 1'b0;
			end else begin
				if (ev) begin
					flag  <= 1'b1; // RULE21
					armed <= 1'b0;
				end else if (w_sc && armed && !wdata[`TPC_BIT_FLAG]) begin
					flag  <= 1'b0; // RULE21
					armed <= 1'b0;
				end else if (r_sc && flag) begin
					armed <= 1'b1;
				end
				if (cap_ev) begin
					val <= cnt; // RULE7
				end
				if (w_sc) begin
					ie    <= wdata[`TPC_BIT_IE];
					msb   <= wdata[`TPC_BIT_MSB];
					msa   <= wdata[`TPC_BIT_MSA];
					els   <= wdata[`TPC_ELS_HI:`TPC_ELS_LO];
					lat   <= 1'b0; // RULE8
					hdone <= 1'b0;
					ldone <= 1'b0;
					wh    <= 1'b0; // RULE9
					wl    <= 1'b0;
				end else if (cap) begin
					if (r_vh || r_vl) begin
						if (!lat) begin
							vbuf <= val; // RULE8
						end
						if ((r_vh && ldone) || (r_vl && hdone)) begin
							lat   <= 1'b0;
							hdone <= 1'b0;
							ldone <= 1'b0;
						end else begin
							lat   <= 1'b1;
							hdone <= hdone | r_vh;
							ldone <= ldone | r_vl;
						end
					end
				end else if (wh && wl && load) begin
					val <= vbuf; // RULE9
					wh  <= 1'b0;
					wl  <= 1'b0;
				end else begin
					if (w_vh) begin
						vbuf[15:8] <= wdata;
						wh         <= 1'b1;
					end
					if (w_vl) begin
						vbuf[7:0] <= wdata;
						wl        <= 1'b1;
					end
				end
				if (epwm || cen) begin
					pout <= els[0] ? ~lt : lt; // RULE4 RULE5
				end else if (cmp && match) begin
					case (els)
					2'b01:   pout <= ~pout; // RULE3
					2'b10:   pout <= 1'b0;
					2'b11:   pout <= 1'b1;
					default: pout <= pout;
					endcase
				end
			end
		end

		always @* begin
			rsel = 8'h00;
			if (addr == A_SC) begin
				rsel = {flag, ie, msb, msa, els, 2'b00};
			end else if (addr == A_VH) begin
				rsel = lat ? vbuf[15:8] : val[15:8];
			end else if (addr == A_VL) begin
				rsel = lat ? vbuf[7:0] : val[7:0];
			end
		end

		assign ch_rd[8*i +: 8]  = rsel;
		assign chan_pin_out[i] = pout;
		assign chan_pin_oe[i]  = pin_en && (cmp || epwm || cen); // RULE1
		assign chan_irq[i]     = flag & ie;
	end
	endgenerate

	// ------------------------------------------------------------
	// read data, valid in the cycle after the strobe
	// ------------------------------------------------------------
	reg [7:0] next_rdata;
	integer j;
	always @* begin
		next_rdata = 8'h00;
		case (addr)
		`TPC_OFS_TSC:  next_rdata = {counter_overflow_flag, overflow_irq_enable,
			center_pwm_select, clock_source_field, prescale};
		`TPC_OFS_CNTH: next_rdata = cnt_lat ? cnt_snap[15:8] : cnt[15:8];
		`TPC_OFS_CNTL: next_rdata = cnt_lat ? cnt_snap[7:0] : cnt[7:0];
		`TPC_OFS_MODH: next_rdata = modv[15:8];
		`TPC_OFS_MODL: next_rdata = modv[7:0];
		default: begin
			for (j = 0; j < NCH; j = j + 1) begin
				next_rdata = next_rdata | ch_rd[8*j +: 8];
			end
		end
		endcase
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
		end
	end
endmodule
`default_nettype wire

// File: tpc_timer_props.sv
// port assertions for the timer top, bound into it
`timescale 1ns/1ps
`default_nettype none
`include "tpc_regs.vh"
module tpc_timer_props #(
	parameter NCH = 2
) (
	input wire logic                   clk,
	input wire logic                   rstn,
	input wire logic [`TPC_ADDR_W-1:0] addr,
	input wire logic [7:0]             wdata,
	input wire logic                   wr,
	input wire logic [NCH-1:0]         chan_pin_oe,
	input wire logic [NCH-1:0]         chan_irq,
	input wire logic                   ovf_irq
);
	// ----------------------------------------
	// shadow of the channel 0 and timer controls
	// ----------------------------------------
	logic       cpwm;
	logic       tie;
	logic       cie;
	logic [1:0] mode;
	logic [1:0] els;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{cpwm, tie, cie, mode, els} <= 7'h00;
		end else if (wr && addr == 5'h00) begin
			tie  <= wdata[6];
			cpwm <= wdata[5];
		end else if (wr && addr == 5'h05) begin
			{cie, mode, els} <= wdata[6:2];
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_ovf_mask: assert property (!tie |-> !ovf_irq)
		else $error("overflow request while disabled");
	a_ovf_hold: assert property (ovf_irq && !(wr && addr == 5'h00) |=> ovf_irq)
		else $error("overflow request dropped");
	a_chan_mask: assert property (!cie |-> !chan_irq[0])
		else $error("channel request while disabled");
	a_chan_hold: assert property (chan_irq[0] && !(wr && addr == 5'h05) |=> chan_irq[0])
		else $error("channel request dropped");
	a_pin_release: assert property (els == 2'h0 |-> !chan_pin_oe[0])
		else $error("released pin driven");
	a_capture_input: assert property (!cpwm && mode == 2'h0 |-> !chan_pin_oe[0])
		else $error("capture pin driven");
	a_compare_drive: assert property (!cpwm && mode != 2'h0 && els != 2'h0 |-> chan_pin_oe[0])
		else $error("compare pin not driven");
	a_center_drive: assert property (cpwm && els != 2'h0 |-> chan_pin_oe[0])
		else $error("center pin not driven");
endmodule
bind tpc_timer tpc_timer_props #(.NCH(NCH)) u_props (
	.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
	.chan_pin_oe(chan_pin_oe), .chan_irq(chan_irq), .ovf_irq(ovf_irq)
);
`default_nettype wire

// File: tpc_pins.sv
// outside world of the timer: channel pin levels and external clock
`timescale 1ns/1ps
`default_nettype none
module tpc_pins #(
	parameter NCH = 2
) (
	input  wire logic           clk,
	input  wire logic           rstn,
	input  wire logic           ext_run,
	input  wire logic [NCH-1:0] ext_level,
	input  wire logic [NCH-1:0] chan_pin_out,
	input  wire logic [NCH-1:0] chan_pin_oe,
	output var  logic           ext_clk,
	output wire logic [NCH-1:0] chan_pin_in
);
	logic div;
	// a driven pin reads back the timer; otherwise the outside level
	assign chan_pin_in = (chan_pin_oe & chan_pin_out) | (~chan_pin_oe & ext_level);
	// quarter of the bus rate, the fastest source allowed; still when idle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div     <= 1'b0;
			ext_clk <= 1'b0;
		end else if (ext_run) begin
			div <= ~div;
			if (div) ext_clk <= ~ext_clk;
		end
	end
endmodule
`default_nettype wire

// File: tpc_timer_bench.sv
// self-checking bench of the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tpc_regs.vh"
module tpc_timer_bench;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        bdm = 1'b0;
	logic        ext_run = 1'b0;
	logic [1:0]  ext_lvl = 2'h0;
	wire  [7:0]  rdata;
	wire  [1:0]  pin_out, pin_oe, pin_in, ch_irq;
	wire         ovf_irq, ext_clk;
	int          error_cnt = 0;
	int          num_checks = 0;
	logic [7:0]  d;
	logic [15:0] v, w;
	always #10 clk = ~clk;
	tpc_timer #(.NCH(2)) dut (
		.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .bdm_active(bdm), .fixed_system_clock(ext_clk), .ext_clk(ext_clk),
		.chan_pin_in(pin_in), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
		.chan_irq(ch_irq), .ovf_irq(ovf_irq)
	);
	tpc_pins #(.NCH(2)) pins (
		.clk(clk), .rstn(rstn), .ext_run(ext_run), .ext_level(ext_lvl),
		.chan_pin_out(pin_out), .chan_pin_oe(pin_oe), .ext_clk(ext_clk),
		.chan_pin_in(pin_in)
	);
	// ----------------------------------------
	// bus and check helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] b);
		@(posedge clk);
		addr  <= a;
		wdata <= b;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] b);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		b = rdata;
	endtask
	task automatic rd16(input logic [4:0] a, output logic [15:0] b);
		rd_reg(a, b[15:8]);
		rd_reg(a + 5'h01, b[7:0]);
	endtask
	task automatic pin(input logic b);
		@(posedge clk);
		ext_lvl[0] <= b;
	endtask
	task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic in_range(input string s, input logic [15:0] lo, hi, g);
		check(s, 16'h1, {15'h0, g >= lo && g <= hi});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		for (int a = 0; a < 11; a++) begin
			rd_reg(a[4:0], d);
			check("reset value", 16'h0, {8'h0, d});
		end
		rd_reg(5'h1F, d);
		check("unmapped", 16'h0, {8'h0, d});
		$display("test reset done");
	endtask
	task automatic t_count;
		wr_reg(`TPC_OFS_CNTL, 8'h00);
		cyc(20);
		rd16(`TPC_OFS_CNTH, v);
		check("clock off", 16'h0, v);
		pin(1'b0);
		bdm <= 1'b1;
		wr_reg(`TPC_OFS_TSC, 8'h08);
		cyc(20);
		rd16(`TPC_OFS_CNTH, v);
		check("debug hold", 16'h0, v);
		pin(1'b0);
		bdm <= 1'b0;
		wr_reg(`TPC_OFS_CNTL, 8'h00);
		rd_reg(`TPC_OFS_CNTH, d);
		cyc(300);
		rd_reg(`TPC_OFS_CNTL, v[7:0]);
		in_range("snapshot", 16'h0, 16'h6, {d, v[7:0]});
		rd16(`TPC_OFS_CNTH, v);
		in_range("running", 16'd300, 16'd315, v);
		pin(1'b0);
		ext_run <= 1'b1;
		wr_reg(`TPC_OFS_TSC, 8'h18);
		wr_reg(`TPC_OFS_CNTL, 8'h00);
		cyc(80);
		rd16(`TPC_OFS_CNTH, v);
		in_range("external", 16'd16, 16'd23, v);
		// the fixed clock input shares the slow pin clock here
		wr_reg(`TPC_OFS_TSC, 8'h10);
		wr_reg(`TPC_OFS_CNTL, 8'h00);
		cyc(80);
		rd16(`TPC_OFS_CNTH, v);
		in_range("fixed clock", 16'd16, 16'd23, v);
		wr_reg(`TPC_OFS_TSC, 8'h0A);
		wr_reg(`TPC_OFS_CNTL, 8'h00);
		cyc(80);
		rd16(`TPC_OFS_CNTH, v);
		in_range("prescaled", 16'd17, 16'd23, v);
		wr_reg(`TPC_OFS_TSC, 8'h08);
		$display("test count done");
	endtask
	task automatic t_ovf;
		wr_reg(`TPC_OFS_MODH, 8'h00);
		wr_reg(`TPC_OFS_MODL, 8'h09);
		wr_reg(`TPC_OFS_CNTL, 8'h00);
		cyc(30);
		check("masked", 16'h0, {15'h0, ovf_irq});
		rd16(`TPC_OFS_CNTH, v);
		in_range("limit", 16'h0, 16'h9, v);
		wr_reg(`TPC_OFS_TSC, 8'h48);
		cyc(1);
		check("overflow", 16'h1, {15'h0, ovf_irq});
		wr_reg(`TPC_OFS_TSC, 8'h40);
		cyc(1);
		check("no read", 16'h1, {15'h0, ovf_irq});
		rd_reg(`TPC_OFS_TSC, d);
		wr_reg(`TPC_OFS_TSC, 8'h40);
		cyc(1);
		check("cleared", 16'h0, {15'h0, ovf_irq});
		wr_reg(`TPC_OFS_TSC, 8'h28);
		wr_reg(5'h05, 8'h08);
		wr_reg(5'h08, 8'h08);
		cyc(40);
		check("center drive", 16'h3, {14'h0, pin_oe});
		rd_reg(`TPC_OFS_TSC, d);
		check("center flag", 16'h1, {15'h0, d[7]});
		rd16(`TPC_OFS_CNTH, v);
		in_range("center count", 16'h0, 16'h9, v);
		$display("test overflow done");
	endtask
	task automatic t_capture;
		wr_reg(`TPC_OFS_TSC, 8'h08);
		wr_reg(`TPC_OFS_MODL, 8'h00);
		wr_reg(`TPC_OFS_MODH, 8'h00);
		wr_reg(5'h05, 8'h04);
		cyc(10);
		// the center-pwm matches left the flag set; clear it first
		rd_reg(5'h05, d);
		wr_reg(5'h05, 8'h04);
		rd_reg(5'h05, d);
		check("flag cleared", 16'h0, {15'h0, d[7]});
		wr_reg(`TPC_OFS_CNTL, 8'h00);
		cyc(20);
		pin(1'b1);
		cyc(10);
		rd_reg(5'h05, d);
		check("edge flag", 16'h1, {15'h0, d[7]});
		rd16(5'h06, w);
		in_range("captured", 16'd21, 16'd29, w);
		rd_reg(5'h06, d);
		pin(1'b0);
		cyc(10);
		pin(1'b1);
		cyc(10);
		rd_reg(5'h07, v[7:0]);
		check("latched", w, {d, v[7:0]});
		rd16(5'h06, v);
		in_range("recapture", w + 16'd18, w + 16'd32, v);
		for (int i = 1; i < 4; i++) begin
			rd_reg(5'h05, d);
			wr_reg(5'h05, {4'h4, i[1:0], 2'h0});
			pin(i == 2);
			cyc(10);
			rd_reg(5'h05, d);
			check("edge select", {15'h0, i == 3}, {15'h0, d[7]});
			check("chan request", {15'h0, i == 3}, {15'h0, ch_irq[0]});
		end
		$display("test capture done");
	endtask
	task automatic t_compare;
		wr_reg(`TPC_OFS_MODH, 8'h00);
		wr_reg(`TPC_OFS_MODL, 8'h3F);
		wr_reg(5'h05, 8'h1C);
		rd16(5'h06, w);
		wr_reg(5'h06, 8'h12);
		rd16(5'h06, v);
		check("half write", w, v);
		wr_reg(5'h07, 8'h34);
		rd16(5'h06, v);
		check("full write", 16'h1234, v);
		wr_reg(5'h07, 8'h20);
		wr_reg(5'h05, 8'h1C);
		wr_reg(5'h06, 8'h00);
		rd16(5'h06, v);
		check("cancelled", 16'h1234, v);
		wr_reg(5'h07, 8'h20);
		rd16(5'h06, v);
		check("compare value", 16'h0020, v);
		for (int i = 3; i >= 0; i--) begin
			rd_reg(5'h05, d);
			wr_reg(5'h05, {4'h1, i[1:0], 2'h0});
			wr_reg(`TPC_OFS_CNTL, 8'h00);
			cyc(40);
			check("drive", {15'h0, i != 0}, {15'h0, pin_oe[0]});
			if (i != 0) check("pin", {15'h0, i != 2}, {15'h0, pin_out[0]});
			rd_reg(5'h05, d);
			check("match flag", 16'h1, {15'h0, d[7]});
			if (i == 1) begin
				cyc(64);
				check("toggle", 16'h0, {15'h0, pin_out[0]});
			end
		end
		$display("test compare done");
	endtask
	task automatic t_pwm;
		for (int i = 1; i < 3; i++) begin
			wr_reg(5'h05, {4'h2, i[1:0], 2'h0});
			wr_reg(5'h06, 8'h00);
			wr_reg(5'h07, 8'h10);
			wr_reg(`TPC_OFS_CNTL, 8'h00);
			cyc(6);
			check("pwm early", {15'h0, i == 2}, {15'h0, pin_out[0]});
			cyc(30);
			check("pwm late", {15'h0, i == 1}, {15'h0, pin_out[0]});
		end
		// a new duty written mid-period must wait for the wrap
		wr_reg(5'h06, 8'h00);
		wr_reg(5'h07, 8'h30);
		cyc(1);
		check("pwm held", 16'h0, {15'h0, pin_out[0]});
		cyc(50);
		check("pwm loaded", 16'h1, {15'h0, pin_out[0]});
		$display("test pwm done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_count();
		t_ovf();
		t_capture();
		t_compare();
		t_pwm();
		tally_and_finish();
	end
	initial begin
		#400000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
